// ---- avs_device.sv ----
// Attenuator register set, serial slave and step code generator.
// Contract
// (RULE1) First frame bit: zero writes, one reads.
// (RULE2) Next two bits address one of four registers.
// (RULE3) Register zero holds the 10-bit direct code.
// (RULE4) Register one holds the 10-bit step increment.
// (RULE5) Register two holds the 10-bit step decrement.
// (RULE6) Register three D9 stores comparator enable.
// (RULE7) Register three reads enable D9, comparator D8.
// (RULE8) Mode low drives the stored direct code.
// (RULE9) Mode high derives code from step pulses.
// (RULE10) Both step pins low clears stepped code.
// (RULE11) Up pulse with down high adds increment.
// (RULE12) Down pulse with up high subtracts decrement.
// (RULE13) Stepped code saturates, never wraps.
// (RULE14) Reference select low internal, high external.
// (RULE15) Write latches on select rise, short frames dropped.
// (RULE16) Read data follows address, ten bits, then released.
// (RULE17) Stepped code clamped 0..1023; pins ignored direct.
// (RULE18) Mode changes keep both codes.
// (RULE19) Bits sampled on rising clock, MSB first.
// (RULE20) Registers and step code clear at reset.
`timescale 1ns/1ps
module avs_device
    import avs_pkg::*;
(
    // System.
    input wire logic clk,
    input wire logic rst_b,
    // Link.
    avs_if.device link,
    // Outputs to the analog side.
    output logic [avs_pkg::DATA_W-1:0] dac_code,
    output logic ext_ref_sel,
    output logic comparator_enable
);
    import avs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [6:0] sync1;
    logic [6:0] sync2;
    // Reset matches the idle pins: select high, both step pins high, so no false edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 7'h0e;
            sync2 <= 7'h0e;
        end else begin
            sync1 <= {link.comp_out_pin, link.ref_sel_pin, link.mode_pin,
                      link.step_down_pin, link.step_up_pin, link.cs_b, link.sdi};
            sync2 <= sync1;
        end
    end
    logic sclk_s;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s <= 1'b0;
        end else begin
            sclk_s <= link.sclk;
        end
    end
    logic sclk_s2;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_s2 <= 1'b0;
        end else begin
            sclk_s2 <= sclk_s;
        end
    end

    wire sdi_s = sync2[0];
    wire cs_b_s = sync2[1];
    wire up_s = sync2[2];
    wire down_s = sync2[3];
    wire mode_s = sync2[4];
    wire ref_s = sync2[5];
    wire comp_s = sync2[6];

    logic sclk_d;
    logic cs_b_d;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d <= 1'b0;
            cs_b_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s2;
            cs_b_d <= cs_b_s;
        end
    end
    wire sclk_rise = sclk_s2 && !sclk_d && !cs_b_s;
    wire sclk_fall = !sclk_s2 && sclk_d && !cs_b_s;
    wire cs_rise = cs_b_s && !cs_b_d;

    // ------------------------------------------------------------
    // Serial frame
    // ------------------------------------------------------------
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [FRAME_BITS-1:0] shift_in;
    logic [DATA_W-1:0] direct_dac_code;
    logic [DATA_W-1:0] step_increment;
    logic [DATA_W-1:0] step_decrement;
    logic [DATA_W-1:0] shift_out;
    logic [BIT_CNT_W-1:0] out_left;

    wire [FRAME_BITS-1:0] next_shift_in = {shift_in[FRAME_BITS-2:0], sdi_s}; // RULE19
    wire frame_dir = shift_in[FRAME_BITS-1]; // RULE1
    wire [ADDR_W-1:0] frame_addr = shift_in[FRAME_BITS-2 -: ADDR_W]; // RULE2
    wire [DATA_W-1:0] frame_data = shift_in[DATA_W-1:0];
    wire frame_full = bit_cnt == BIT_CNT_W'(FRAME_BITS);
    wire do_write = cs_rise && frame_full && frame_dir == DIR_WRITE; // RULE15
    wire addr_done = sclk_rise && bit_cnt == BIT_CNT_W'(2);
    wire read_start = addr_done && shift_in[1] == DIR_READ; // RULE16
    wire [ADDR_W-1:0] read_addr = {shift_in[0], sdi_s};

    function automatic logic [DATA_W-1:0] reg_value(input logic [ADDR_W-1:0] a,
                                                    input logic [DATA_W-1:0] d0,
                                                    input logic [DATA_W-1:0] d1,
                                                    input logic [DATA_W-1:0] d2,
                                                    input logic en,
                                                    input logic cmp);
        case (a)
            REG_DIRECT: reg_value = d0; // RULE3
            REG_INC: reg_value = d1; // RULE4
            REG_DEC: reg_value = d2; // RULE5
            default: reg_value = {en, cmp, 8'h00}; // RULE7
        endcase
    endfunction

    wire [DATA_W-1:0] read_word = reg_value(read_addr, direct_dac_code, step_increment,
                                            step_decrement, comparator_enable, comp_s);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt <= '0;
            shift_in <= '0;
        end else if (cs_b_s) begin
            bit_cnt <= '0;
        end else if (sclk_rise) begin
            shift_in <= next_shift_in;
            if (!frame_full) begin
                bit_cnt <= bit_cnt + BIT_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            direct_dac_code <= REG_RESET; // RULE20
            step_increment <= REG_RESET;
            step_decrement <= REG_RESET;
            comparator_enable <= 1'b0;
        end else if (do_write) begin
            case (frame_addr)
                REG_DIRECT: direct_dac_code <= frame_data; // RULE3
                REG_INC: step_increment <= frame_data; // RULE4
                REG_DEC: step_decrement <= frame_data; // RULE5
                default: comparator_enable <= frame_data[COMP_EN_BIT]; // RULE6
            endcase
        end
    end

    // Output shifts on the falling serial edge so the host samples on the rising one.
    // The first bit goes out on the falling edge after the last address bit.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_out <= '0;
            out_left <= '0;
            link.sdo <= 1'b0;
            link.sdo_oe <= 1'b0;
        end else if (cs_b_s) begin
            out_left <= '0; // RULE16
            link.sdo_oe <= 1'b0;
        end else if (read_start) begin
            shift_out <= read_word; // RULE16
            out_left <= BIT_CNT_W'(DATA_W + 1);
        end else if (sclk_fall && out_left != '0) begin
            out_left <= out_left - BIT_CNT_W'(1);
            if (out_left == BIT_CNT_W'(1)) begin
                link.sdo_oe <= 1'b0; // RULE16
            end else begin
                link.sdo <= shift_out[DATA_W-1]; // RULE19
                link.sdo_oe <= 1'b1;
                shift_out <= {shift_out[DATA_W-2:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // Step code
    // ------------------------------------------------------------
    logic [DATA_W-1:0] step_code;
    logic up_d;
    logic down_d;
    wire up_pulse = up_s && !up_d && down_s; // RULE11
    wire down_pulse = down_s && !down_d && up_s; // RULE12
    wire [DATA_W:0] sum = {1'b0, step_code} + {1'b0, step_increment};
    wire [DATA_W-1:0] sum_sat = sum[DATA_W] ? CODE_MAX : sum[DATA_W-1:0]; // RULE13
    wire [DATA_W-1:0] diff_sat = (step_code < step_decrement) ? REG_RESET
                               : step_code - step_decrement; // RULE17

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_code <= REG_RESET; // RULE20
            up_d <= 1'b1;
            down_d <= 1'b1;
        end else begin
            up_d <= up_s;
            down_d <= down_s;
            if (mode_s) begin // RULE9
                if (!up_s && !down_s) begin
                    step_code <= REG_RESET; // RULE10
                end else if (up_pulse) begin
                    step_code <= sum_sat;
                end else if (down_pulse) begin
                    step_code <= diff_sat;
                end
            end
        end
    end

    // Both codes are held apart so switching modes loses neither.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_code <= REG_RESET;
            ext_ref_sel <= 1'b0;
        end else begin
            dac_code <= mode_s ? step_code : direct_dac_code; // RULE8 RULE18
            ext_ref_sel <= ref_s; // RULE14
        end
    end
endmodule

// ---- avs_pkg.sv ----
// Package with the shared constants of the attenuator register stepper link.
package avs_pkg;
    localparam int DATA_W = 10;
    localparam int ADDR_W = 2;
    localparam int FRAME_BITS = 13;
    localparam int BIT_CNT_W = 4;
    localparam logic [DATA_W-1:0] CODE_MAX = 10'h3ff;
    localparam logic [DATA_W-1:0] REG_RESET = 10'h000;
    localparam logic [ADDR_W-1:0] REG_DIRECT = 2'h0;
    localparam logic [ADDR_W-1:0] REG_INC = 2'h1;
    localparam logic [ADDR_W-1:0] REG_DEC = 2'h2;
    localparam logic [ADDR_W-1:0] REG_COMP = 2'h3;
    localparam int COMP_EN_BIT = 9;
    localparam int COMP_OUT_BIT = 8;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    // Host side AHB-Lite register offsets (byte addresses).
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RDATA = 8'h08;
    localparam logic [7:0] OFS_PINS = 8'h0c;
    // Command register fields.
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 16;
    localparam int CMD_DIR_BIT = 18;
    // Pin control register fields.
    localparam int PIN_UP_BIT = 0;
    localparam int PIN_DOWN_BIT = 1;
    localparam int PIN_MODE_BIT = 2;
    localparam int PIN_REF_BIT = 3;
    localparam logic [3:0] PINS_RESET = 4'h3;
    // Serial clock divider: half period in system clocks.
    localparam int SCLK_HALF = 8;
    localparam int DIV_W = 4;
endpackage

// ---- avs_if.sv ----
// Interface joining the serial link and control pins of both ends.
`timescale 1ns/1ps
interface avs_if;
    logic sclk;
    logic cs_b;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic step_up_pin;
    logic step_down_pin;
    logic mode_pin;
    logic ref_sel_pin;
    logic comp_out_pin;

    modport device (
        input sclk, cs_b, sdi, step_up_pin, step_down_pin, mode_pin, ref_sel_pin,
        input comp_out_pin,
        output sdo, sdo_oe
    );
    modport host (
        output sclk, cs_b, sdi, step_up_pin, step_down_pin, mode_pin, ref_sel_pin,
        input sdo, sdo_oe
    );
endinterface

// ---- avs_host.sv ----
// Serial master and step pin driver with an AHB-Lite register port.
`timescale 1ns/1ps
module avs_host
    import avs_pkg::*;
(
    // System.
    input wire logic clk,
    input wire logic rst_b,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link.
    avs_if.host link
);
    import avs_pkg::*;

    typedef enum {AVS_IDLE, AVS_LOW, AVS_HIGH, AVS_END} avs_state_t;
    avs_state_t state;
    logic [DIV_W-1:0] div;
    logic [4:0] bit_idx;
    logic [FRAME_BITS-1:0] frame;
    logic [DATA_W-1:0] rdata;
    logic busy;
    logic [3:0] pins;
    logic sdo_s1;
    logic sdo_s2;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic wr_pend;
    logic [7:0] wr_addr;
    wire take = hsel && hready && htrans[1];
    wire start = wr_pend && wr_addr == OFS_CMD && !busy; // RULE1
    wire [31:0] status_word = {31'h0, busy};
    wire [31:0] read_mux = (haddr == OFS_STATUS) ? status_word
                         : (haddr == OFS_RDATA) ? {22'h0, rdata}
                         : (haddr == OFS_PINS) ? {28'h0, pins} : 32'h0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            pins <= PINS_RESET;
        end else begin
            wr_pend <= take && hwrite;
            if (take) begin
                wr_addr <= haddr;
            end
            if (take && !hwrite) begin
                hrdata <= read_mux;
            end
            if (wr_pend && wr_addr == OFS_PINS) begin
                pins <= hwdata[3:0];
            end
        end
    end
    assign link.step_up_pin = pins[PIN_UP_BIT]; // RULE11
    assign link.step_down_pin = pins[PIN_DOWN_BIT]; // RULE12
    assign link.mode_pin = pins[PIN_MODE_BIT];
    assign link.ref_sel_pin = pins[PIN_REF_BIT];

    // ------------------------------------------------------------
    // Serial master
    // ------------------------------------------------------------
    wire div_done = div == DIV_W'(SCLK_HALF - 1);
    // Direction is kept apart because the frame register shifts away its top bit.
    logic is_read;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sdo_s1 <= 1'b0;
            sdo_s2 <= 1'b0;
        end else begin
            sdo_s1 <= link.sdo;
            sdo_s2 <= sdo_s1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= AVS_IDLE;
            div <= '0;
            bit_idx <= '0;
            frame <= '0;
            rdata <= '0;
            busy <= 1'b0;
            is_read <= 1'b0;
            link.sclk <= 1'b0;
            link.cs_b <= 1'b1;
            link.sdi <= 1'b0;
        end else begin
            div <= div_done ? '0 : div + DIV_W'(1);
            case (state)
                AVS_IDLE: begin
                    if (start) begin
                        frame <= {hwdata[CMD_DIR_BIT], hwdata[CMD_ADDR_LSB +: ADDR_W],
                                  hwdata[CMD_DATA_LSB +: DATA_W]}; // RULE2 RULE6
                        link.sdi <= hwdata[CMD_DIR_BIT]; // RULE19
                        is_read <= hwdata[CMD_DIR_BIT] == DIR_READ; // RULE1
                        link.cs_b <= 1'b0;
                        busy <= 1'b1;
                        bit_idx <= '0;
                        div <= '0;
                        state <= AVS_LOW;
                    end
                end
                AVS_LOW: begin
                    if (div_done) begin
                        link.sclk <= 1'b1;
                        if (is_read && bit_idx >= 5'd3) begin
                            rdata <= {rdata[DATA_W-2:0], sdo_s2}; // RULE16 RULE19
                        end
                        state <= AVS_HIGH;
                    end
                end
                AVS_HIGH: begin
                    if (div_done) begin
                        link.sclk <= 1'b0;
                        if (bit_idx == 5'(FRAME_BITS - 1)) begin
                            state <= AVS_END;
                        end else begin
                            bit_idx <= bit_idx + 5'd1;
                            frame <= {frame[FRAME_BITS-2:0], 1'b0};
                            link.sdi <= frame[FRAME_BITS-2];
                            state <= AVS_LOW;
                        end
                    end
                end
                AVS_END: begin
                    if (div_done) begin
                        link.cs_b <= 1'b1; // RULE15
                        busy <= 1'b0;
                        state <= AVS_IDLE;
                    end
                end
                default: state <= AVS_IDLE;
            endcase
        end
    end
endmodule

// ---- avs_link_properties.sv ----
// Checker for the serial link between the host and device ends.
`timescale 1ns/1ps
module avs_link_properties (
    // System.
    input wire logic clk,
    input wire logic rst_b,
    // Link.
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // Frame counters
    // ----------------------------------------
    // Rising serial clocks in the frame, and falling ones while the device drives.
    logic [3:0] rise_cnt;
    logic [3:0] fall_cnt;
    logic dir_bit;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_cnt <= 4'h0;
            dir_bit <= 1'b0;
        end else if (cs_b) begin
            rise_cnt <= 4'h0;
        end else if ($rose(sclk)) begin
            rise_cnt <= rise_cnt + 4'h1;
            if (rise_cnt == 4'h0) begin
                dir_bit <= sdi;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fall_cnt <= 4'h0;
        end else if ($rose(sdo_oe)) begin
            fall_cnt <= 4'h0;
        end else if (sdo_oe && $fell(sclk)) begin
            fall_cnt <= fall_cnt + 4'h1;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_frame_end;
        $rose(cs_b);
    endsequence
    sequence s_drive_start;
        $rose(sdo_oe);
    endsequence

    property p_sclk_in_frame;
        sclk |-> !cs_b;
    endproperty
    property p_frame_len;
        s_frame_end |-> rise_cnt == 4'hd;
    endproperty
    property p_sdi_hold;
        sclk && $past(sclk) |-> $stable(sdi);
    endproperty
    property p_oe_start;
        s_drive_start |-> !cs_b && rise_cnt == 4'h3;
    endproperty
    property p_read_only;
        s_drive_start |-> dir_bit;
    endproperty
    property p_oe_len;
        $fell(sdo_oe) && !cs_b |-> fall_cnt == 4'ha;
    endproperty
    property p_oe_release;
        s_frame_end |-> ##[0:6] !sdo_oe;
    endproperty
    property p_sdo_hold;
        sdo_oe && $past(sdo_oe) && sclk && $past(sclk) |-> $stable(sdo);
    endproperty

    a_sclk_in_frame: assert property (p_sclk_in_frame)
        else $error("serial clock toggles outside a frame");
    a_frame_len: assert property (p_frame_len)
        else $error("frame not thirteen bits long");
    a_sdi_hold: assert property (p_sdi_hold)
        else $error("serial input moved while clock high");
    a_oe_start: assert property (p_oe_start)
        else $error("read data started at the wrong bit");
    a_read_only: assert property (p_read_only)
        else $error("device drove output in a write frame");
    a_oe_len: assert property (p_oe_len)
        else $error("read data not ten bits long");
    a_oe_release: assert property (p_oe_release)
        else $error("output not released after select rose");
    a_sdo_hold: assert property (p_sdo_hold)
        else $error("serial output moved while clock high");
endmodule

// ---- attenuator_dac_register_stepper_bench.sv ----
// Testbench joining host and device ends and checking registers and code.
`timescale 1ns/1ps
module attenuator_dac_register_stepper_bench;
    import avs_pkg::*;
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, res_vld;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, res_val, s;
    logic [DATA_W-1:0] dac_code, r0, inc, dec, q;
    logic ext_ref_sel, comparator_enable;
    logic [31:0] exp_q[$];
    string nm_q[$];
    int fail_count, checked, step, i;

    avs_if link_if();
    avs_host avs_host_i(.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link(link_if));
    avs_device avs_device_i(.clk(clk), .rst_b(rst_b), .link(link_if), .dac_code(dac_code),
        .ext_ref_sel(ext_ref_sel), .comparator_enable(comparator_enable));
    avs_link_properties avs_link_properties_i(.clk(clk), .rst_b(rst_b), .sclk(link_if.sclk),
        .cs_b(link_if.cs_b), .sdi(link_if.sdi), .sdo(link_if.sdo), .sdo_oe(link_if.sdo_oe));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ----------------------------------------
    // Bus and link tasks
    // ----------------------------------------
    task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr; hsize <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Notes the expectation and presents the observed value to the watcher.
    task automatic note(input string n, input logic [31:0] e, input logic [31:0] v);
        exp_q.push_back(e);
        nm_q.push_back(n);
        res_val <= v;
        res_vld <= 1'b1;
        @(posedge clk);
        res_vld <= 1'b0;
        @(posedge clk);
    endtask

    task automatic frame(input logic dir, input logic [1:0] a, input logic [9:0] d);
        logic [31:0] c;
        int n;
        c = 32'h0;
        c[9:0] = d;
        c[17:16] = a;
        c[CMD_DIR_BIT] = dir;
        ahb(OFS_CMD, 1'b1, c, s);
        repeat (2) @(posedge clk);
        s = 32'h1;
        for (n = 0; n < 500 && s[0] !== 1'b0; n++) ahb(OFS_STATUS, 1'b0, 32'h0, s);
        if (s[0] !== 1'b0) begin
            fail_count++;
            $display("CHECK FAILED busy expected 0 seen %h", s[0]);
        end
        ahb(OFS_RDATA, 1'b0, 32'h0, s);
        q = s[9:0];
    endtask

    task automatic rd_reg(input logic [1:0] a, input logic [9:0] e);
        frame(DIR_READ, a, 10'h000);
        note($sformatf("register %0d", a), {22'h0, e}, {22'h0, q});
    endtask

    // Pin bits: up, down, mode, reference select from the bottom.
    task automatic pins(input logic [3:0] p);
        ahb(OFS_PINS, 1'b1, {28'h0, p}, s);
        repeat (8) @(posedge clk);
    endtask

    task automatic dac(input int e);
        note("dac_code", 32'(e), {22'h0, dac_code});
    endtask

    always @(posedge clk) begin
        if (res_vld === 1'b1) begin
            checked++;
            if (res_val !== exp_q[0]) begin
                fail_count++;
                $display("CHECK FAILED %s expected %h seen %h", nm_q[0], exp_q[0], res_val);
            end
            void'(exp_q.pop_front());
            void'(nm_q.pop_front());
        end
    end

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        close_out();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst_b = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; res_vld = 1'b0; res_val = 32'h0;
        link_if.comp_out_pin = 1'b0; fail_count = 0; checked = 0; step = 0;
        void'($urandom(54));
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 4; i++) rd_reg(i[1:0], 10'h000);
        dac(0);
        $display("test reset values done");
        r0 = 10'($urandom);
        inc = 10'h100 + 10'($urandom % 256);
        dec = 10'h080 + 10'($urandom % 256);
        frame(DIR_WRITE, REG_DIRECT, r0);
        frame(DIR_WRITE, REG_INC, inc);
        frame(DIR_WRITE, REG_DEC, dec);
        frame(DIR_WRITE, REG_COMP, 10'h200);
        link_if.comp_out_pin <= 1'b1;
        rd_reg(REG_DIRECT, r0);
        rd_reg(REG_INC, inc);
        rd_reg(REG_DEC, dec);
        rd_reg(REG_COMP, 10'h300);
        note("comparator_enable", 32'h1, {31'h0, comparator_enable});
        frame(DIR_WRITE, REG_COMP, 10'h000);
        rd_reg(REG_COMP, 10'h100);
        ahb(8'h10, 1'b0, 32'h0, s);
        note("unmapped read", 32'h0, s);
        note("hresp", 32'h0, {31'h0, hresp});
        $display("test register access done");
        dac(r0);
        pins(4'h2);
        pins(4'h3);
        dac(r0);
        pins(4'h4);
        dac(0);
        pins(4'h5);
        pins(4'h7);
        for (i = 0; i < 5; i++) begin
            pins(4'h6);
            pins(4'h7);
            step = (step + inc > 1023) ? 1023 : step + inc;
            dac(step);
        end
        pins(4'h3);
        dac(r0);
        pins(4'h7);
        dac(step);
        for (i = 0; i < 9; i++) begin
            pins(4'h5);
            pins(4'h7);
            step = (step < dec) ? 0 : step - dec;
            dac(step);
        end
        pins(4'h6);
        pins(4'h7);
        pins(4'h4);
        dac(0);
        $display("test stepping done");
        pins(4'hf);
        note("ext_ref_sel", 32'h1, {31'h0, ext_ref_sel});
        pins(4'h7);
        note("ext_ref_sel", 32'h0, {31'h0, ext_ref_sel});
        $display("test reference select done");
        close_out();
    end
endmodule
